//--- core/sctx_top.v
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "sctx_defines.vh"
module sctx_top #(
	parameter DEPTH = 2,
	parameter PTR_W = 1,
	parameter ETU_CLKS = `SCTX_ETU_CARD_CLKS
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`SCTX_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire card_clk,
	input wire io_in,
	output reg io_out,
	output reg io_oe_n,
	input wire rlen_at_limit,
	output reg irq
);
	localparam S_IDLE = 2'b00;
	localparam S_BITS = 2'b01;
	localparam S_GUARD = 2'b10;
	localparam [15:0] ETU_LAST = ETU_CLKS - 1;
	localparam [15:0] ETU_HALF = ETU_CLKS / 2;

	reg [7:0] fifo_mem [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_reg;
	reg [PTR_W-1:0] rd_ptr_reg;
	reg [PTR_W:0] count_reg;
	reg direct_reg, final_reg, dir_reg, tx_mode_reg;
	reg undr_reg, break_reg;
	reg [7:0] card_ctrl_reg, config_reg, mask_reg, stat_reg;
	reg [2:0] clk_sync_reg;
	reg [1:0] io_sync_reg;
	reg [15:0] etu_cnt_reg;
	reg [1:0] state_reg;
	reg [3:0] bit_cnt_reg;
	reg [9:0] shift_reg;
	reg [7:0] byte_reg;
	reg is_sum_reg;
	reg guard_err_reg;
	reg [15:0] crc_reg;
	reg [1:0] sum_idx_reg;
	reg full_d_reg, empty_d_reg;

	wire [15:0] idx = paddr[`SCTX_ADDR_W-1:2];
	wire setup = psel && !penable;
	wire access = psel && penable && pready;
	wire wr_acc = access && pwrite;
	wire rd_acc = access && !pwrite;
	wire hit_ctrl = idx == `SCTX_IDX_TX_CTRL;
	wire hit_data = idx == `SCTX_IDX_TX_DATA;
	wire mapped = hit_ctrl || hit_data || idx == `SCTX_IDX_RX_CTRL ||
		idx == `SCTX_IDX_CARD_CTRL || idx == `SCTX_IDX_IRQ_STAT ||
		idx == `SCTX_IDX_IRQ_MASK || idx == `SCTX_IDX_CONFIG;

	wire t1 = config_reg[`SCTX_B_T1];
	wire crc_en = config_reg[`SCTX_B_CRC_EN];
	wire crc16 = config_reg[`SCTX_B_CRC16];
	wire fifo_empty = count_reg == 0;
	wire fifo_full = count_reg == DEPTH;
	wire busy = state_reg != S_IDLE;
	wire [1:0] sum_len = crc16 ? 2'd2 : 2'd1;
	wire sum_pending = t1 && crc_en && final_reg && sum_idx_reg < sum_len;
	wire empty_flag = fifo_empty && !(final_reg && (busy || sum_pending));
	wire direct_on = config_reg[`SCTX_B_SYNC] && direct_reg &&
		rlen_at_limit;

	// Card clock sampled as data; only stages two and three feed the edge
	wire card_rise = clk_sync_reg[1] && !clk_sync_reg[2];
	wire etu_end = card_rise && etu_cnt_reg == ETU_LAST;
	wire etu_mid = card_rise && etu_cnt_reg == ETU_HALF;
	wire io_s = io_sync_reg[1];

	wire ctrl_wr = wr_acc && hit_ctrl;
	wire dir_wr = pwdata[`SCTX_B_DIR];
	wire push = wr_acc && hit_data;
	wire mpu_pop = rd_acc && hit_data && !fifo_empty;
	wire start = state_reg == S_IDLE && tx_mode_reg && !direct_on &&
		(!fifo_empty || sum_pending);
	wire hw_pop = start && !fifo_empty;
	wire pop = mpu_pop || hw_pop;
	wire done = state_reg == S_GUARD && etu_end && bit_cnt_reg == 4'd1 &&
		!guard_err_reg;
	wire brk_evt = state_reg == S_GUARD && etu_mid && bit_cnt_reg == 4'd0 &&
		!io_s && !t1;
	wire undr_evt = done && !is_sum_reg && fifo_empty && !final_reg &&
		!push;
	wire crc_clear = ctrl_wr && dir_wr != dir_reg;
	wire [7:0] sum_byte = (crc16 && sum_idx_reg == 0) ? crc_reg[15:8] :
		crc_reg[7:0];
	wire [7:0] next_byte = fifo_empty ? sum_byte : fifo_mem[rd_ptr_reg];

	function [15:0] crc_step;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c ^ {d, 8'h00};
			for (i = 0; i < 8; i = i + 1)
				r = r[15] ? ((r << 1) ^ `SCTX_CRC_POLY) : (r << 1);
			crc_step = r;
		end
	endfunction

	reg [7:0] rd_val;
	always @*
	begin
		rd_val = 8'h00;
		case (idx)
			`SCTX_IDX_TX_CTRL: rd_val = {direct_reg, 1'b0, fifo_full,
				empty_flag, undr_reg, final_reg, dir_reg, break_reg};
			`SCTX_IDX_TX_DATA: rd_val = fifo_mem[rd_ptr_reg];
			`SCTX_IDX_CARD_CTRL: rd_val = card_ctrl_reg;
			`SCTX_IDX_IRQ_STAT: rd_val = stat_reg;
			`SCTX_IDX_IRQ_MASK: rd_val = mask_reg;
			`SCTX_IDX_CONFIG: rd_val = config_reg;
			default: rd_val = 8'h00;
		endcase
	end

	// Events and sticky interrupt status; a set beats a same-cycle clear
	wire [7:0] evt = {4'h0, brk_evt, undr_evt, empty_flag && !empty_d_reg,
		fifo_full && !full_d_reg};
	wire stat_wr = wr_acc && idx == `SCTX_IDX_IRQ_STAT;
	reg [7:0] stat_next;
	always @*
	begin
		stat_next = stat_reg;
		if (stat_wr)
			stat_next = stat_reg & ~pwdata[7:0];
		stat_next = stat_next | evt;
	end

	// APB: no wait states, read data captured in setup
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			stat_reg <= 8'h00;
			irq <= 1'b0;
			mask_reg <= `SCTX_RST_IRQ_MASK;
			config_reg <= `SCTX_RST_CONFIG;
			card_ctrl_reg <= `SCTX_RST_CARD_CTRL;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup)
				prdata <= {24'h000000, rd_val};
			stat_reg <= stat_next;
			irq <= |(stat_next & mask_reg);
			if (wr_acc && idx == `SCTX_IDX_IRQ_MASK)
				mask_reg <= pwdata[7:0];
			if (wr_acc && idx == `SCTX_IDX_CONFIG)
				config_reg <= pwdata[7:0];
			if (wr_acc && idx == `SCTX_IDX_CARD_CTRL)
				card_ctrl_reg <= pwdata[7:0];
		end
	end

	// Control bits, sticky flags, direction
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			direct_reg <= 1'b0;
			final_reg <= 1'b0;
			dir_reg <= 1'b0;
			tx_mode_reg <= 1'b0;
			undr_reg <= 1'b0;
			break_reg <= 1'b0;
			full_d_reg <= 1'b0;
			empty_d_reg <= 1'b1;
		end
		else
		begin
			full_d_reg <= fifo_full;
			empty_d_reg <= empty_flag;
			if (ctrl_wr)
			begin
				direct_reg <= pwdata[`SCTX_B_DIRECT];
				final_reg <= pwdata[`SCTX_B_FINAL];
				dir_reg <= dir_wr;
			end
			// Receive asked early with a final byte: drain first
			if (ctrl_wr && dir_wr)
				tx_mode_reg <= 1'b1;
			else if (ctrl_wr && !(final_reg && !empty_flag))
				tx_mode_reg <= 1'b0;
			else if (!dir_reg && empty_flag)
				tx_mode_reg <= 1'b0;
			// Clear only what the read actually showed
			if (rd_acc && hit_ctrl && prdata[`SCTX_B_UNDR])
				undr_reg <= 1'b0;
			if (rd_acc && hit_ctrl && prdata[`SCTX_B_BREAK])
				break_reg <= 1'b0;
			if (undr_evt)
				undr_reg <= 1'b1;
			if (brk_evt)
				break_reg <= 1'b1;
		end
	end

	// FIFO; entries are never cleared, only overwritten
	always @(posedge pclk)
	begin
		if (push)
			fifo_mem[wr_ptr_reg] <= pwdata[7:0];
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr_reg <= {PTR_W{1'b0}};
			rd_ptr_reg <= {PTR_W{1'b0}};
			count_reg <= {(PTR_W+1){1'b0}};
		end
		else
		begin
			// A push while full overwrites the slot, as the card allows
			if (push && !fifo_full)
				wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {PTR_W{1'b0}} :
					wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {PTR_W{1'b0}} :
					rd_ptr_reg + 1'b1;
			if ((push && !fifo_full) && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !(push && !fifo_full))
				count_reg <= count_reg - 1'b1;
		end
	end

	// Serial engine: start, 8 data LSB first, even parity, 2 guard ETUs
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_sync_reg <= 3'b000;
			io_sync_reg <= 2'b11;
			etu_cnt_reg <= 16'h0000;
			state_reg <= S_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 10'h3FF;
			byte_reg <= `SCTX_RST_TX_DATA;
			is_sum_reg <= 1'b0;
			guard_err_reg <= 1'b0;
			crc_reg <= `SCTX_CRC_INIT;
			sum_idx_reg <= 2'd0;
			io_out <= 1'b1;
			io_oe_n <= 1'b1;
		end
		else
		begin
			clk_sync_reg <= {clk_sync_reg[1:0], card_clk};
			io_sync_reg <= {io_sync_reg[0], io_in};
			if (start)
				etu_cnt_reg <= 16'h0000;
			else if (card_rise)
				etu_cnt_reg <= (etu_cnt_reg == ETU_LAST) ? 16'h0000 :
					etu_cnt_reg + 16'h0001;
			case (state_reg)
				S_IDLE:
				begin
					if (start)
					begin
						byte_reg <= next_byte;
						is_sum_reg <= fifo_empty;
						shift_reg <= {^next_byte, next_byte, 1'b0};
						bit_cnt_reg <= 4'd9;
						state_reg <= S_BITS;
					end
				end
				S_BITS:
				begin
					if (etu_end)
					begin
						shift_reg <= {1'b1, shift_reg[9:1]};
						if (bit_cnt_reg == 4'd0)
							state_reg <= S_GUARD;
						else
							bit_cnt_reg <= bit_cnt_reg - 4'd1;
					end
				end
				S_GUARD:
				begin
					if (brk_evt)
						guard_err_reg <= 1'b1;
					if (etu_end && bit_cnt_reg == 4'd0)
						bit_cnt_reg <= 4'd1;
					else if (etu_end)
					begin
						guard_err_reg <= 1'b0;
						bit_cnt_reg <= 4'd9;
						// Card flagged parity error: repeat the byte
						if (guard_err_reg)
						begin
							shift_reg <= {^byte_reg, byte_reg, 1'b0};
							state_reg <= S_BITS;
						end
						else
							state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
			// Checksum covers message bytes only
			if (crc_clear || !final_reg)
				sum_idx_reg <= 2'd0;
			else if (done && is_sum_reg)
				sum_idx_reg <= sum_idx_reg + 2'd1;
			if (crc_clear)
				crc_reg <= crc16 ? `SCTX_CRC_INIT : 16'h0000;
			else if (done && !is_sum_reg)
				crc_reg <= crc16 ? crc_step(crc_reg, byte_reg) :
					{8'h00, crc_reg[7:0] ^ byte_reg};
			if (direct_on)
			begin
				io_out <= card_ctrl_reg[`SCTX_B_CARD_IO];
				io_oe_n <= card_ctrl_reg[`SCTX_B_CARD_IO];
			end
			else
			begin
				io_out <= state_reg == S_BITS ? shift_reg[0] : 1'b1;
				io_oe_n <= state_reg == S_BITS ? shift_reg[0] : 1'b1;
			end
		end
	end
endmodule

//--- common/sctx_defines.vh
`ifndef SCTX_DEFINES_VH
`define SCTX_DEFINES_VH
// Register indexes; byte address is four times the index
`define SCTX_IDX_TX_CTRL 16'hFE06
`define SCTX_IDX_TX_DATA 16'hFE07
`define SCTX_IDX_RX_CTRL 16'hFE08
`define SCTX_IDX_CARD_CTRL 16'hFE0A
`define SCTX_IDX_IRQ_STAT 16'hFE40
`define SCTX_IDX_IRQ_MASK 16'hFE41
`define SCTX_IDX_CONFIG 16'hFE42
`define SCTX_ADDR_W 18
// Reset values
`define SCTX_RST_TX_CTRL 8'h00
`define SCTX_RST_TX_DATA 8'h00
`define SCTX_RST_CARD_CTRL 8'h21
`define SCTX_RST_CONFIG 8'h00
`define SCTX_RST_IRQ_MASK 8'h00
// Transmit control/status fields
`define SCTX_B_DIRECT 7
`define SCTX_B_FULL 5
`define SCTX_B_EMPTY 4
`define SCTX_B_UNDR 3
`define SCTX_B_FINAL 2
`define SCTX_B_DIR 1
`define SCTX_B_BREAK 0
// Card control IO bit
`define SCTX_B_CARD_IO 6
// Config fields
`define SCTX_B_T1 0
`define SCTX_B_CRC_EN 1
`define SCTX_B_CRC16 2
`define SCTX_B_SYNC 3
// Interrupt status / mask fields
`define SCTX_I_FULL 0
`define SCTX_I_EMPTY 1
`define SCTX_I_UNDR 2
`define SCTX_I_BREAK 3
// Timing and checksum
`define SCTX_ETU_CARD_CLKS 372
`define SCTX_CRC_INIT 16'hFFFF
`define SCTX_CRC_POLY 16'h1021
`endif

//--- sim/sctx_assertions.sv
`timescale 1ns/1ps
`include "sctx_defines.vh"
module sctx_assertions (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`SCTX_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire card_clk,
	input wire io_in,
	input wire io_out,
	input wire io_oe_n,
	input wire rlen_at_limit,
	input wire irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_single: assert property (s_access |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property ((s_setup
		and (paddr[17:2] < `SCTX_IDX_TX_CTRL)) |=> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property ((s_setup
		and (paddr[17:2] == `SCTX_IDX_TX_DATA)) |=> !pslverr)
		else $error("data access refused");
	a_open_drain: assert property (io_oe_n == io_out)
		else $error("enable and level differ");
	a_start_hold: assert property ($fell(io_out) |=> !io_out [*8])
		else $error("start bit too short");
endmodule

//--- sim/sctx_card_model.sv
`timescale 1ns/1ps
module sctx_card_model (
	input wire card_clk,
	input wire io_line,
	input wire brk_en,
	output reg io_pull_n,
	output reg [23:0] hist,
	output reg [3:0] n_rx
);
	reg [8:0] sh;
	reg used;
	integer k;
	initial
	begin
		io_pull_n = 1;
		hist = 0;
		n_rx = 0;
		used = 0;
		forever
		begin
			@(negedge io_line);
			// Sample near mid bit, one ETU is four clocks
			repeat (2) @(posedge card_clk);
			for (k = 0; k < 9; k = k + 1)
			begin
				repeat (4) @(posedge card_clk);
				sh = {io_line, sh[8:1]};
			end
			if (!brk_en)
				used = 0;
			if (brk_en && !used)
			begin
				used = 1;
				@(posedge card_clk);
				io_pull_n = 0;
				repeat (8) @(posedge card_clk);
				io_pull_n = 1;
			end
			else
			begin
				hist = {hist[15:0], sh[7:0]};
				n_rx = n_rx + 1;
			end
		end
	end
endmodule

//--- sim/smart_card_tx_control_tb.sv
`timescale 1ns/1ps
`include "sctx_defines.vh"
module smart_card_tx_control_tb;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg card_clk = 0, rlen_at_limit = 0, brk_en = 0, err;
	reg [17:0] paddr = 0;
	reg [31:0] pwdata = 0;
	reg [7:0] rd;
	wire [31:0] prdata;
	wire pready, pslverr, io_out, io_oe_n, irq, io_pull_n, io_line;
	wire [23:0] hist;
	wire [3:0] n_rx;
	integer miscompares = 0, cmp_count = 0, cyc = 0;
	// Open drain line with pull-up
	assign io_line = io_oe_n & io_pull_n;
	sctx_top #(.ETU_CLKS(4)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .card_clk(card_clk), .io_in(io_line),
		.io_out(io_out), .io_oe_n(io_oe_n),
		.rlen_at_limit(rlen_at_limit), .irq(irq));
	sctx_card_model i_card (.card_clk(card_clk), .io_line(io_line),
		.brk_en(brk_en), .io_pull_n(io_pull_n), .hist(hist), .n_rx(n_rx));
	initial forever #12.5 pclk = ~pclk;
	initial forever #100 card_clk = ~card_clk;
	task tally_and_finish;
	begin
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	always @(posedge pclk)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	end
	task chk(input string nm, input [23:0] e, input [23:0] s);
	begin
		cmp_count = cmp_count + 1;
		if (e !== s)
		begin
			miscompares = miscompares + 1;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	end
	endtask
	task apb(input w, input [15:0] i, input [7:0] d);
	begin
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
	end
	endtask
	task rc(input string nm, input [15:0] i, input [7:0] m, input [7:0] e);
	begin
		apb(0, i, 8'h00);
		chk(nm, e, rd & m);
	end
	endtask
	task wait_rx(input [3:0] n);
		integer k;
	begin
		k = 0;
		while (n_rx !== n && k < 20000)
		begin
			@(posedge pclk);
			k = k + 1;
		end
		chk("rx_count", n, n_rx);
		// Let the two guard times pass
		repeat (100) @(posedge pclk);
	end
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rc("card_ctrl", `SCTX_IDX_CARD_CTRL, 8'hFF, 8'h21);
		rc("tx_ctrl", `SCTX_IDX_TX_CTRL, 8'h30, 8'h10);
		rc("mask", `SCTX_IDX_IRQ_MASK, 8'hFF, 8'h00);
		apb(0, 16'hFE01, 8'h00);
		chk("slverr", 1, err);
		apb(1, `SCTX_IDX_IRQ_MASK, 8'h0F);
		apb(1, `SCTX_IDX_TX_DATA, 8'hA1);
		apb(1, `SCTX_IDX_TX_DATA, 8'hB2);
		rc("full", `SCTX_IDX_TX_CTRL, 8'h30, 8'h20);
		rc("irq_full", `SCTX_IDX_IRQ_STAT, 8'h01, 8'h01);
		chk("irq", 1, irq);
		apb(1, `SCTX_IDX_IRQ_MASK, 8'h00);
		repeat (2) @(posedge pclk);
		chk("irq_masked", 0, irq);
		apb(1, `SCTX_IDX_IRQ_MASK, 8'h0F);
		rc("head", `SCTX_IDX_TX_DATA, 8'hFF, 8'hA1);
		rc("next", `SCTX_IDX_TX_DATA, 8'hFF, 8'hB2);
		rc("empty", `SCTX_IDX_TX_CTRL, 8'h30, 8'h10);
		chk("rx_idle", 0, n_rx);
		apb(1, `SCTX_IDX_IRQ_STAT, 8'h0F);
		repeat (2) @(posedge pclk);
		chk("irq_clear", 0, irq);
		apb(1, `SCTX_IDX_TX_CTRL, 8'h02);
		apb(1, `SCTX_IDX_TX_DATA, 8'hA5);
		wait_rx(1);
		chk("byte", 8'hA5, hist[7:0]);
		rc("undr", `SCTX_IDX_TX_CTRL, 8'h08, 8'h08);
		rc("undr_rd", `SCTX_IDX_TX_CTRL, 8'h08, 8'h00);
		rc("irq_st", `SCTX_IDX_IRQ_STAT, 8'h06, 8'h06);
		chk("irq_on", 1, irq);
		apb(1, `SCTX_IDX_TX_CTRL, 8'h00);
		apb(1, `SCTX_IDX_CONFIG, 8'h03);
		apb(1, `SCTX_IDX_TX_DATA, 8'h12);
		apb(1, `SCTX_IDX_TX_DATA, 8'h34);
		apb(1, `SCTX_IDX_TX_CTRL, 8'h06);
		rc("t1_busy", `SCTX_IDX_TX_CTRL, 8'h10, 8'h00);
		wait_rx(4);
		chk("lrc", 24'h123426, hist);
		rc("t1_done", `SCTX_IDX_TX_CTRL, 8'h18, 8'h10);
		apb(1, `SCTX_IDX_TX_CTRL, 8'h02);
		apb(1, `SCTX_IDX_CONFIG, 8'h00);
		brk_en <= 1;
		apb(1, `SCTX_IDX_TX_DATA, 8'h5A);
		apb(1, `SCTX_IDX_TX_CTRL, 8'h06);
		apb(1, `SCTX_IDX_TX_CTRL, 8'h04);
		rc("t0_busy", `SCTX_IDX_TX_CTRL, 8'h10, 8'h00);
		wait_rx(5);
		chk("resent", 8'h5A, hist[7:0]);
		rc("brk", `SCTX_IDX_TX_CTRL, 8'h13, 8'h11);
		rc("brk_rd", `SCTX_IDX_TX_CTRL, 8'h01, 8'h00);
		rc("irq_brk", `SCTX_IDX_IRQ_STAT, 8'h08, 8'h08);
		brk_en <= 0;
		apb(1, `SCTX_IDX_TX_CTRL, 8'h00);
		apb(1, `SCTX_IDX_CONFIG, 8'h08);
		rlen_at_limit <= 1;
		apb(1, `SCTX_IDX_TX_CTRL, 8'h80);
		apb(1, `SCTX_IDX_CARD_CTRL, 8'h21);
		repeat (20) @(posedge pclk);
		chk("direct_lo", 0, io_out);
		apb(1, `SCTX_IDX_CARD_CTRL, 8'h61);
		repeat (20) @(posedge pclk);
		chk("direct_hi", 1, io_out);
		tally_and_finish;
	end
endmodule
bind sctx_top sctx_assertions i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.card_clk(card_clk), .io_in(io_in), .io_out(io_out),
	.io_oe_n(io_oe_n), .rlen_at_limit(rlen_at_limit), .irq(irq));
